// ==== logic/cid_core.sv ====
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - add-with-carry sums acc, register and carry; sets carry, nibble carry, zero.
// - subtract-with-borrow takes acc and borrow from register; sets three flags.
// - arithmetic right shift keeps sign bit; sets carry and zero only.
// - rotate left through carry; only carry changes.
// - rotate right through carry; only carry changes.
// - or of acc and register; only zero changes.
// - xor of acc and register; only zero changes.
// - decrement register, no flags, skip next word on zero result.
// - increment register, no flags, skip next word on zero result.
// - bit test skips next word when selected bit is zero.
// - bit test skips next word when selected bit is one.
// - literal minus acc into acc; sets carry, nibble carry, zero.
// - xor literal into acc; only zero changes.
// - or literal into acc; only zero changes.
// - load seven-bit literal into page latch; flags untouched.
// - program counter change or true test costs a second no-op cycle.
// - indirect window access with pointer msb set costs one extra cycle.
module cid_core import cid_pkg::*; (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic instr_valid,
	input wire logic [13:0] instr_word,
	output logic instr_ready,
	output logic pc_load,
	output logic [14:0] pc_target
);
	logic rst_meta_b;
	logic rst_sync_b;
	logic ap_wr_reg;
	logic [7:0] ap_addr_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] rd_val;
	logic run_reg;
	logic [7:0] acc_reg;
	logic [2:0] flags_reg;
	logic [6:0] page_reg;
	logic [15:0] ptr0_reg;
	logic [15:0] ptr1_reg;
	logic [6:0] didx_reg;
	logic ill_reg;
	logic ready_reg;
	logic pc_load_reg;
	logic [14:0] pc_target_reg;
	logic [13:0] word_reg;
	cid_state_e state_reg;
	cid_state_e state_next;
	logic accept;
	logic ind_slow;
	logic lit_file;
	logic exec;
	logic [6:0] faddr;
	logic [6:0] eaddr;
	logic [7:0] operand;
	logic [7:0] bus_rd;
	logic [7:0] alu_res;
	logic [2:0] alu_flg;
	logic [2:0] alu_upd;
	logic alu_wr_acc;
	logic alu_wr_reg;
	logic alu_skip;
	logic alu_page_wr;
	logic alu_legal;
	logic pc_wr;
	logic core_dwe;

	// bus write hit in the data phase
	function automatic logic bw(input logic [7:0] a);
		bw = ap_wr_reg && (ap_addr_reg == a);
	endfunction

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	// zero wait state slave, read data captured in address phase
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ap_wr_reg <= 1'b0;
			ap_addr_reg <= 8'h00;
			hrdata_reg <= 32'h0000_0000;
		end else begin
			ap_wr_reg <= hsel && hready && htrans[1] && hwrite && (hsize == HSIZE_WORD);
			ap_addr_reg <= haddr[7:0];
			if (hsel && hready && htrans[1] && !hwrite) begin
				hrdata_reg <= rd_val;
			end
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		case (haddr[7:0])
			ADDR_CTRL: rd_val[0] = run_reg;
			ADDR_ACC: rd_val[7:0] = acc_reg;
			ADDR_FLAGS: rd_val[2:0] = flags_reg;
			ADDR_PAGE: rd_val[6:0] = page_reg;
			ADDR_PTR0: rd_val[15:0] = ptr0_reg;
			ADDR_PTR1: rd_val[15:0] = ptr1_reg;
			ADDR_STATE: rd_val[ILL_BIT:0] = {ill_reg, 6'h00, state_reg};
			ADDR_DIDX: rd_val[6:0] = didx_reg;
			ADDR_DATA: rd_val[7:0] = bus_rd;
			default: rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			run_reg <= RUN_RST;
			ptr0_reg <= PTR_RST;
			ptr1_reg <= PTR_RST;
			didx_reg <= 7'h00;
		end else begin
			if (bw(ADDR_CTRL)) begin
				run_reg <= hwdata[0];
			end
			if (bw(ADDR_PTR0)) begin
				ptr0_reg <= hwdata[15:0];
			end
			if (bw(ADDR_PTR1)) begin
				ptr1_reg <= hwdata[15:0];
			end
			if (bw(ADDR_DIDX)) begin
				didx_reg <= hwdata[6:0];
			end
		end
	end

	assign accept = ready_reg && instr_valid;
	assign exec = (state_reg == S_EXEC);
	assign lit_file = (instr_word[13:12] == CLS_LIT) && ((instr_word[11:8] == OP_ADDC) ||
		(instr_word[11:8] == OP_SUBB) || (instr_word[11:8] == OP_ASR));
	assign ind_slow = ((instr_word[13:12] != CLS_LIT) || lit_file) &&
		(((instr_word[6:0] == WIN0) && ptr0_reg[PTR_MSB]) ||
		((instr_word[6:0] == WIN1) && ptr1_reg[PTR_MSB]));
	assign faddr = word_reg[6:0];
	assign eaddr = (faddr == WIN0) ? ptr0_reg[6:0] :
		(faddr == WIN1) ? ptr1_reg[6:0] : faddr;
	assign pc_wr = alu_wr_reg && (eaddr == PC_LOW);
	assign core_dwe = exec && alu_wr_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			S_FETCH: begin
				if (accept) begin
					state_next = ind_slow ? S_IND : S_EXEC;
				end
			end
			S_IND: state_next = S_EXEC;
			S_EXEC: state_next = (alu_skip || pc_wr) ? S_NOP : S_FETCH;
			// skipped or stale word is swallowed here
			S_NOP: begin
				if (accept) begin
					state_next = S_FETCH;
				end
			end
			default: state_next = S_FETCH;
		endcase
	end

	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state_reg <= S_FETCH;
			ready_reg <= 1'b0;
			word_reg <= 14'h0000;
		end else begin
			state_reg <= state_next;
			ready_reg <= run_reg && ((state_next == S_FETCH) || (state_next == S_NOP));
			if (accept && (state_reg == S_FETCH)) begin
				word_reg <= instr_word;
			end
		end
	end

	cid_alu u_alu (
		.word(word_reg),
		.acc(acc_reg),
		.opnd(operand),
		.c_in(flags_reg[FLAG_C]),
		.res(alu_res),
		.flg(alu_flg),
		.upd(alu_upd),
		.wr_acc(alu_wr_acc),
		.wr_reg(alu_wr_reg),
		.skip(alu_skip),
		.page_wr(alu_page_wr),
		.legal(alu_legal)
	);

	cid_data_file #(.DEPTH(128), .WIDTH(8)) u_data (
		.clock(clock),
		.rd_a_addr(eaddr),
		.rd_a_data(operand),
		.rd_b_addr(didx_reg),
		.rd_b_data(bus_rd),
		.wr_en(core_dwe || bw(ADDR_DATA)),
		.wr_addr(core_dwe ? eaddr : didx_reg),
		.wr_data(core_dwe ? alu_res : hwdata[7:0])
	);

	// core writes win over bus writes
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			acc_reg <= ACC_RST;
			flags_reg <= FLAGS_RST;
			page_reg <= PAGE_RST;
		end else begin
			if (exec && alu_wr_acc) begin
				acc_reg <= alu_res;
			end else if (bw(ADDR_ACC)) begin
				acc_reg <= hwdata[7:0];
			end
			for (int i = 0; i < 3; i++) begin
				if (exec && alu_upd[i]) begin
					flags_reg[i] <= alu_flg[i];
				end else if (bw(ADDR_FLAGS)) begin
					flags_reg[i] <= hwdata[i];
				end
			end
			if (exec && alu_page_wr) begin
				page_reg <= word_reg[6:0];
			end else if (bw(ADDR_PAGE)) begin
				page_reg <= hwdata[6:0];
			end
		end
	end

	// unsupported word is a no-op; sticky flag, set beats clear
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ill_reg <= 1'b0;
			pc_load_reg <= 1'b0;
			pc_target_reg <= 15'h0000;
		end else begin
			if (exec && !alu_legal) begin
				ill_reg <= 1'b1;
			end else if (bw(ADDR_STATE) && hwdata[ILL_BIT]) begin
				ill_reg <= 1'b0;
			end
			pc_load_reg <= exec && pc_wr;
			if (exec && pc_wr) begin
				pc_target_reg <= {page_reg, alu_res};
			end
		end
	end

	assign hrdata = hrdata_reg;
	assign hreadyout = rst_sync_b;
	assign hresp = 1'b0;
	assign instr_ready = ready_reg;
	assign pc_load = pc_load_reg;
	assign pc_target = pc_target_reg;

	logic [8:0] chk_add;
	assign chk_add = {1'b0, acc_reg} + {1'b0, operand} + {8'h00, flags_reg[FLAG_C]};

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_sync_b);

	a_skip_nop: assert property (exec && alu_skip |=> state_reg == S_NOP ##1 1'b1)
		else $error("true test did not add a no-op cycle");
	a_plain_one: assert property (exec && !alu_skip && !pc_wr |=> state_reg == S_FETCH)
		else $error("plain instruction took more than one cycle");
	a_ind_extra: assert property (accept && state_reg == S_FETCH && ind_slow
		|=> state_reg == S_IND ##1 state_reg == S_EXEC)
		else $error("slow indirect access lacked its extra cycle");
	a_ind_fast: assert property (accept && state_reg == S_FETCH && !ind_slow
		|=> state_reg == S_EXEC)
		else $error("direct access was delayed");
	a_acc_dest: assert property (exec && alu_wr_acc |=> acc_reg == $past(alu_res))
		else $error("acc not loaded with result");
	a_zero_flag: assert property (exec && alu_upd[FLAG_Z]
		|=> flags_reg[FLAG_Z] == ($past(alu_res) == 8'h00))
		else $error("zero flag wrong");
	a_rot_carry: assert property (exec && word_reg[13:8] == {CLS_BYTE, OP_RLC}
		|=> flags_reg[FLAG_C] == $past(operand[7]) && $stable(flags_reg[FLAG_Z]))
		else $error("rotate left carry wrong");
	a_page_load: assert property (exec && alu_page_wr
		|=> page_reg == $past(word_reg[6:0]) && $stable(flags_reg))
		else $error("page latch load wrong");
	a_add_carry: assert property (exec && word_reg[13:8] == {CLS_LIT, OP_ADDC}
		|=> flags_reg[FLAG_C] == $past(chk_add[8]))
		else $error("add carry flag wrong");

	c_skip: cover property (exec && alu_skip ##1 state_reg == S_NOP);
	c_slow: cover property (state_reg == S_IND ##1 exec);
	c_pcl: cover property (pc_load_reg);
endmodule // cid_core
`default_nettype wire

// ==== logic/cid_pkg.sv ====
`default_nettype none
package cid_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_ACC = 8'h04;
	localparam logic [7:0] ADDR_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_PAGE = 8'h0C;
	localparam logic [7:0] ADDR_PTR0 = 8'h10;
	localparam logic [7:0] ADDR_PTR1 = 8'h14;
	localparam logic [7:0] ADDR_STATE = 8'h18;
	localparam logic [7:0] ADDR_DIDX = 8'h1C;
	localparam logic [7:0] ADDR_DATA = 8'h20;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam int FLAG_C = 0;
	localparam int FLAG_DC = 1;
	localparam int FLAG_Z = 2;
	localparam int DEST_BIT = 7;
	localparam int PTR_MSB = 15;
	localparam int ILL_BIT = 8;
	localparam logic [1:0] CLS_BYTE = 2'h0;
	localparam logic [1:0] CLS_BIT = 2'h1;
	localparam logic [1:0] CLS_LIT = 2'h3;
	localparam logic [3:0] OP_IOR = 4'h4;
	localparam logic [3:0] OP_XOR = 4'h6;
	localparam logic [3:0] OP_DECSZ = 4'hB;
	localparam logic [3:0] OP_INCSZ = 4'hF;
	localparam logic [3:0] OP_RLC = 4'hD;
	localparam logic [3:0] OP_RRC = 4'hC;
	localparam logic [3:0] OP_ADDC = 4'hD;
	localparam logic [3:0] OP_SUBB = 4'hB;
	localparam logic [3:0] OP_ASR = 4'h7;
	localparam logic [3:0] OP_XORL = 4'hA;
	localparam logic [3:0] OP_IORL = 4'h8;
	localparam logic [3:0] OP_PAGE = 4'h1;
	localparam logic [2:0] OP_SUBL_HI = 3'h6;
	localparam logic [6:0] WIN0 = 7'h00;
	localparam logic [6:0] WIN1 = 7'h01;
	localparam logic [6:0] PC_LOW = 7'h02;
	localparam logic RUN_RST = 1'b0;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [2:0] FLAGS_RST = 3'h0;
	localparam logic [6:0] PAGE_RST = 7'h00;
	localparam logic [15:0] PTR_RST = 16'h0000;
	typedef enum logic [1:0] {
		S_FETCH = 2'b00,
		S_IND = 2'b01,
		S_EXEC = 2'b10,
		S_NOP = 2'b11
	} cid_state_e;
endpackage
`default_nettype wire

// ==== logic/cid_data_file.sv ====
`timescale 1ns/10ps
`default_nettype none
module cid_data_file #(
	parameter int DEPTH = 128,
	parameter int WIDTH = 8
) (
	input wire logic clock,
	input wire logic [6:0] rd_a_addr,
	output logic [WIDTH-1:0] rd_a_data,
	input wire logic [6:0] rd_b_addr,
	output logic [WIDTH-1:0] rd_b_data,
	input wire logic wr_en,
	input wire logic [6:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	if (DEPTH != 128 || WIDTH != 8) begin : g_chk
		$error("data file must be 128 by 8");
	end
	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end
	assign rd_a_data = mem[rd_a_addr];
	assign rd_b_data = mem[rd_b_addr];
endmodule // cid_data_file
`default_nettype wire

// ==== logic/cid_alu.sv ====
`timescale 1ns/10ps
`default_nettype none
module cid_alu import cid_pkg::*; (
	input wire logic [13:0] word,
	input wire logic [7:0] acc,
	input wire logic [7:0] opnd,
	input wire logic c_in,
	output logic [7:0] res,
	output logic [2:0] flg,
	output logic [2:0] upd,
	output logic wr_acc,
	output logic wr_reg,
	output logic skip,
	output logic page_wr,
	output logic legal
);
	// returns carry, nibble carry, sum
	function automatic logic [9:0] add3(input logic [7:0] a, input logic [7:0] b,
		input logic ci);
		logic [4:0] lo;
		logic [8:0] s;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		add3 = {s[8], lo[4], s[7:0]};
	endfunction
	logic [9:0] sum;
	logic to_dst;
	always_comb begin
		sum = 10'h000;
		to_dst = 1'b0;
		res = 8'h00;
		flg = 3'h0;
		upd = 3'h0;
		wr_acc = 1'b0;
		skip = 1'b0;
		page_wr = 1'b0;
		legal = 1'b1;
		case (word[13:12])
			CLS_BYTE: begin
				to_dst = 1'b1;
				case (word[11:8])
					OP_IOR: res = acc | opnd;
					OP_XOR: res = acc ^ opnd;
					OP_RLC: {flg[FLAG_C], res} = {opnd, c_in};
					OP_RRC: {res, flg[FLAG_C]} = {c_in, opnd};
					OP_DECSZ: begin
						res = opnd - 8'h01;
						skip = (res == 8'h00);
					end
					OP_INCSZ: begin
						res = opnd + 8'h01;
						skip = (res == 8'h00);
					end
					default: begin
						to_dst = 1'b0;
						legal = 1'b0;
					end
				endcase
				upd[FLAG_Z] = (word[11:8] == OP_IOR) || (word[11:8] == OP_XOR);
				upd[FLAG_C] = (word[11:8] == OP_RLC) || (word[11:8] == OP_RRC);
			end
			CLS_BIT: begin
				legal = word[11];
				skip = word[11] && (opnd[word[9:7]] == word[10]) == 1'b0 ? 1'b0 :
					word[11] && (opnd[word[9:7]] == word[10]);
			end
			CLS_LIT: begin
				// only 1100: 1101 belongs to add with carry
				if (word[11:8] == {OP_SUBL_HI, 1'b0}) begin
					sum = add3(word[7:0], ~acc, 1'b1);
					wr_acc = 1'b1;
					upd = 3'h7;
				end else begin
					case (word[11:8])
						OP_ADDC: begin
							sum = add3(acc, opnd, c_in);
							to_dst = 1'b1;
							upd = 3'h7;
						end
						OP_SUBB: begin
							sum = add3(opnd, ~acc, c_in);
							to_dst = 1'b1;
							upd = 3'h7;
						end
						OP_ASR: begin
							{res, flg[FLAG_C]} = {opnd[7], opnd};
							to_dst = 1'b1;
							upd[FLAG_C] = 1'b1;
							upd[FLAG_Z] = 1'b1;
						end
						OP_XORL: begin
							res = acc ^ word[7:0];
							wr_acc = 1'b1;
							upd[FLAG_Z] = 1'b1;
						end
						OP_IORL: begin
							res = acc | word[7:0];
							wr_acc = 1'b1;
							upd[FLAG_Z] = 1'b1;
						end
						OP_PAGE: begin
							page_wr = word[7];
							legal = word[7];
						end
						default: legal = 1'b0;
					endcase
				end
				if (upd[FLAG_DC]) begin
					res = sum[7:0];
					flg[FLAG_C] = sum[9];
					flg[FLAG_DC] = sum[8];
				end
			end
			default: legal = 1'b0;
		endcase
		flg[FLAG_Z] = (res == 8'h00);
		wr_reg = to_dst && word[DEST_BIT];
		wr_acc = wr_acc || (to_dst && !word[DEST_BIT]);
	end
endmodule // cid_alu
`default_nettype wire

// ==== bench/cid_prog_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
module cid_prog_mem (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic slow,
	input wire logic instr_ready,
	output logic instr_valid,
	output logic [13:0] instr_word
);
	logic [13:0] q[$];
	logic took;
	logic more;
	task put(input logic [13:0] w);
		q.push_back(w);
	endtask
	// word held until taken, junk while nothing offered
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			instr_valid <= 1'b0;
			instr_word <= 14'h0000;
		end else begin
			took = instr_valid && instr_ready;
			if (took)
				void'(q.pop_front());
			more = q.size() > 0 && !(took && slow);
			instr_valid <= more;
			instr_word <= more ? q[0] : ~instr_word;
		end
	end
endmodule // cid_prog_mem
`default_nettype wire

// ==== bench/test_core_instruction_decoder.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_core_instruction_decoder import cid_pkg::*;;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b1;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = HSIZE_WORD;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata;
	logic hreadyout, hresp, instr_valid, instr_ready, pc_load;
	logic slow = 1'b0;
	logic rd_ph = 1'b0;
	logic [13:0] instr_word;
	logic [14:0] pc_target;
	logic [31:0] exp_q[$];
	logic [14:0] pc_q[$];
	int cyc_q[$];
	int lo = 0;
	int error_cnt = 0;
	int checks_done = 0;
	int i, idx;
	logic [31:0] seed = 32'h00000029;
	logic [31:0] r, s;
	logic [13:0] w;
	logic [7:0] ea, ef;
	logic [2:0] efl;
	logic eskip;
	logic [5:0] ops [14] = '{6'h3D, 6'h3B, 6'h37, 6'h0D, 6'h0C, 6'h04, 6'h06, 6'h0B, 6'h0F,
		6'h18, 6'h1C, 6'h3C, 6'h3A, 6'h38};

	cid_core i_dut (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .instr_valid(instr_valid),
		.instr_word(instr_word), .instr_ready(instr_ready), .pc_load(pc_load),
		.pc_target(pc_target));
	cid_prog_mem i_pm (.clock(clock), .rst_b(rst_b), .slow(slow), .instr_ready(instr_ready),
		.instr_valid(instr_valid), .instr_word(instr_word));

	initial begin
		forever #4 clock = ~clock;
	end

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_pc(input logic [14:0] got, input logic [14:0] exp);
		cmp({17'h00000, got}, {17'h00000, exp});
	endtask
	task automatic cmp_cyc(input int got, input int exp);
		cmp(32'(got), 32'(exp));
	endtask

	task automatic close_out();
		$display("checks=%0d errors=%0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= !wr;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd_ph <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		xfer(1'b0, a, 32'h00000000);
	endtask

	task automatic wait_done();
		do @(negedge clock); while (i_pm.q.size() != 0 || instr_valid || instr_ready !== 1'b1);
		@(posedge clock);
	endtask

	task automatic model(input logic [13:0] wd);
		logic [7:0] x, y;
		logic ci, co;
		logic [2:0] m;
		logic [8:0] sm;
		logic [4:0] n;
		{x, y, ci, co, m, eskip} = '0;
		case (wd[13:8])
			6'h3D: {x, y, ci, m} = {ea, ef, efl[0], 3'h4};
			6'h3B: {x, y, ci, m} = {ef, ~ea, efl[0], 3'h4};
			6'h3C: {x, y, ci, m} = {wd[7:0], ~ea, 1'b1, 3'h4};
			6'h37: {x, co, m} = {ef[7], ef[7:1], ef[0], 3'h3};
			6'h0D: {co, x, m} = {ef, efl[0], 3'h2};
			6'h0C: {x, co, m} = {efl[0], ef, 3'h2};
			6'h04: {x, m} = {ea | ef, 3'h1};
			6'h06: {x, m} = {ea ^ ef, 3'h1};
			6'h3A: {x, m} = {ea ^ wd[7:0], 3'h1};
			6'h38: {x, m} = {ea | wd[7:0], 3'h1};
			6'h0B: x = ef - 8'h01;
			6'h0F: x = ef + 8'h01;
			default: eskip = ef[wd[9:7]] == wd[10];
		endcase
		sm = x + y + ci;
		n = x[3:0] + y[3:0] + ci;
		if (wd[13:8] inside {6'h0B, 6'h0F})
			eskip = sm[7:0] == 8'h00;
		case (m)
			3'h4: efl = {sm[7:0] == 8'h00, n[4], sm[8]};
			3'h3: efl = {sm[7:0] == 8'h00, efl[1], co};
			3'h2: efl[0] = co;
			3'h1: efl[2] = sm[7:0] == 8'h00;
			default: ;
		endcase
		if (wd[13:8] inside {6'h3C, 6'h3A, 6'h38})
			ea = sm[7:0];
		else if (wd[13:12] != 2'h1 && wd[7])
			ef = sm[7:0];
		else if (wd[13:12] != 2'h1)
			ea = sm[7:0];
	endtask

	always @(posedge clock) begin
		if (rd_ph && hreadyout === 1'b1) begin
			cmp(hrdata, exp_q.pop_front());
			cmp({31'h00000000, hresp}, 32'h00000000);
		end
		if (pc_load === 1'b1)
			cmp_pc(pc_target, pc_q.pop_front());
		if (instr_ready === 1'b1) begin
			if (lo != 0 && cyc_q.size() != 0)
				cmp_cyc(lo, cyc_q.pop_front());
			lo <= 0;
		end else
			lo <= lo + 1;
	end

	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		close_out();
	end

	initial begin
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		repeat (3) @(posedge clock);
		rd(ADDR_ACC, {24'h000000, ACC_RST});
		rd(ADDR_FLAGS, {29'h00000000, FLAGS_RST});
		rd(ADDR_PAGE, {25'h0000000, PAGE_RST});
		rd(ADDR_PTR1, {16'h0000, PTR_RST});
		xfer(1'b1, 8'h3C, 32'hFFFFFFFF);
		rd(8'h3C, 32'h00000000);
		xfer(1'b1, ADDR_CTRL, 32'h00000001);
		xfer(1'b1, ADDR_FLAGS, 32'h00000005);
		i_pm.put({6'h31, 1'b1, 7'h55});
		wait_done();
		rd(ADDR_PAGE, 32'h00000055);
		rd(ADDR_FLAGS, 32'h00000005);
		xfer(1'b1, ADDR_ACC, 32'h0000000F);
		xfer(1'b1, ADDR_DIDX, {25'h0000000, PC_LOW});
		xfer(1'b1, ADDR_DATA, 32'h000000A0);
		pc_q.push_back({7'h55, 8'hAF});
		// flushed word after program counter write
		i_pm.put({6'h04, 1'b1, PC_LOW});
		i_pm.put({6'h3A, 8'hFF});
		wait_done();
		rd(ADDR_ACC, 32'h0000000F);
		rd(ADDR_FLAGS, 32'h00000001);
		for (i = 0; i < 4; i++) begin
			xfer(1'b1, ADDR_PTR0, i[0] ? 32'h00000050 : 32'h00008050);
			cyc_q.push_back(2 - i[0]);
			i_pm.put({i[1] ? 6'h3D : 6'h06, 1'b0, WIN0});
			wait_done();
		end
		// unsupported word: one cycle, sticky flag, write one clears
		i_pm.put(14'h0000);
		cyc_q.push_back(1);
		wait_done();
		rd(ADDR_STATE, 32'h00000100);
		xfer(1'b1, ADDR_STATE, 32'h00000100);
		rd(ADDR_STATE, 32'h00000000);
		for (i = 0; i < 80; i++) begin
			r = rnd();
			s = rnd();
			idx = r[7:0] % 14;
			w = {ops[idx], r[15:8]};
			if (idx < 11)
				w[6:0] = {1'b1, r[13:8]};
			if (idx inside {9, 10})
				w[9:7] = r[18:16];
			{efl, ef, ea} = s[18:0];
			slow <= s[19];
			xfer(1'b1, ADDR_ACC, {24'h000000, ea});
			xfer(1'b1, ADDR_FLAGS, {29'h00000000, efl});
			xfer(1'b1, ADDR_DIDX, {25'h0000000, 1'b1, r[13:8]});
			xfer(1'b1, ADDR_DATA, {24'h000000, ef});
			i_pm.put(w);
			i_pm.put({6'h3A, s[31:24]});
			model(w);
			cyc_q.push_back(1);
			if (!eskip) begin
				model({6'h3A, s[31:24]});
				cyc_q.push_back(1);
			end
			wait_done();
			rd(ADDR_ACC, {24'h000000, ea});
			rd(ADDR_FLAGS, {29'h00000000, efl});
			rd(ADDR_DATA, {24'h000000, ef});
		end
		close_out();
	end
endmodule // test_core_instruction_decoder
`default_nettype wire
